// ==== common/vps_pkg.sv ====
/*
 * constants, types and field layouts shared by the program sequencer
 * and its branch target table.
 * assumes one core clock and word (32-bit) program addresses.
 */
`default_nettype none
package vps_pkg;
   // ************************************************
   // sizes
   // ************************************************
   localparam int PC_W           = 32;  // word address width
   localparam int INSTR_W        = 32;  // one instruction
   localparam int SLOTS          = 4;   // instructions per line
   localparam int LINE_W         = 128; // one instruction line
   localparam int LINE_BUF_LINES = 5;   // lines held by the line buffer
   localparam int FETCH_STAGES   = 4;   // address, request, access, align
   localparam int EXEC_STAGES    = 6;   // execution stages after issue
   localparam int FETCH_LAT      = 2;   // request cycle to data cycle
   localparam int BTT_ENTRIES    = 128; // branch target table size
   localparam int NUM_IRQ        = 8;   // interrupt sources
   localparam int NUM_EXT_IRQ    = 4;   // external_interrupt_lines
   localparam int REG_ID_W       = 6;   // register number width
   localparam int REGS           = 64;  // register numbers tracked
   // ************************************************
   // instruction word fields
   // ************************************************
   localparam int END_BIT = 31; // last instruction of its line
   localparam int UNIT_HI = 30; // target unit
   localparam int UNIT_LO = 29;
   localparam int COND_BIT = 28; // instruction is conditional
   localparam int DST_HI  = 27; // destination register
   localparam int DST_LO  = 22;
   localparam int SRC_HI  = 21; // source register
   localparam int SRC_LO  = 16;
   // ************************************************
   // reset values and fixed sensitivities
   // ************************************************
   localparam logic [PC_W-1:0]    RESET_PC   = 32'h0000_0000;
   localparam logic [NUM_IRQ-1:0] FIXED_EDGE = 8'hc0; // 1 = edge source
   // ************************************************
   // types
   // ************************************************
   typedef enum logic [1:0] {
      UNIT_CX  = 2'h0, // compute block x
      UNIT_CY  = 2'h1, // compute block y
      UNIT_INT = 2'h2, // integer_address_unit
      UNIT_SEQ = 2'h3  // sequencer itself
   } vps_unit_t;
   typedef enum logic [0:0] {
      ST_RUN   = 1'h0, // issuing
      ST_DRAIN = 1'h1  // interrupt waits for pipe to empty
   } vps_state_t;
   typedef struct packed {
      logic            pred; // line ends in a predicted-taken branch
      logic [PC_W-1:0] pc;   // word address
      logic [INSTR_W-1:0] word;
   } vps_qent_t;
endpackage
`default_nettype wire

// ==== common/vps_btt_if.sv ====
/*
 * link between the sequencer and its branch target table memory.
 * assumes both ends share the core clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface vps_btt_if #(parameter int AW = 7, parameter int DW = 58);
   logic [AW-1:0] rd_addr; // read index, data next cycle
   logic [DW-1:0] rd_data; // registered entry
   logic          wr_en;   // write strobe
   logic [AW-1:0] wr_addr; // write index
   logic [DW-1:0] wr_data; // msb is the entry valid bit
   modport ctl (output rd_addr, output wr_en, output wr_addr, output wr_data, input rd_data);
   modport mem (input rd_addr, input wr_en, input wr_addr, input wr_data, output rd_data);
endinterface
`default_nettype wire

// ==== hdl/vps_btt_mem.sv ====
/*
 * branch target table storage: one entry per index, registered read.
 * assumes the msb of each entry is its valid bit, cleared by reset.
 */
`timescale 1ns/1ps
`default_nettype none
module vps_btt_mem #(
   parameter int DEPTH = vps_pkg::BTT_ENTRIES,
   parameter int AW    = 7,
   parameter int DW    = 58
) (
   // clock and reset
   input  wire logic sys_clk_in,
   input  wire logic rst_n_in,
   // table port
   vps_btt_if.mem    btt
);
   logic [DW-2:0]    store [DEPTH]; // entry bodies
   logic [DEPTH-1:0] valid;         // entry valid bits

   // ************************************************
   // body write, no reset needed
   // ************************************************
   always_ff @(posedge sys_clk_in) begin
      if (btt.wr_en) begin
         store[btt.wr_addr] <= btt.wr_data[DW-2:0];
      end
   end

   // valid bits, cleared at reset
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         valid <= '0;
      end else if (btt.wr_en) begin
         valid[btt.wr_addr] <= btt.wr_data[DW-1];
      end
   end

   // registered read
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         btt.rd_data <= '0;
      end else begin
         btt.rd_data <= {valid[btt.rd_addr], store[btt.rd_addr]};
      end
   end
endmodule
`default_nettype wire

// ==== hdl/vps_sequencer.sv ====
/*
 * program sequencer: fetch, line buffer, issue, interlocks, branch
 * prediction, interrupt and exception flow.
 * assumes fetch data arrives two cycles after a request and that the
 * execution units report branch, return and exception events.
 */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - issue one line per cycle, ten stages
// - four fetch stages, six execution stages
// - stall until compute results are ready
// - stall issue on unready integer results
// - buffer five lines, route each instruction
// - 128-entry target table predicts taken branches
// - software exception cancels all pipeline instructions
// - interrupt waits for pipeline to complete
// - each source: vector, latch bit, mask bit
// - fixed sensitivity, external lines selectable
// - nested and non-nested interrupt modes
// - steer flow for branches, returns, interrupts
// - false condition removes instruction effect
// - reassemble lines from unaligned fetch words
// - issue lines in program order, never reordered
module vps_sequencer #(
   parameter int               LINES    = vps_pkg::LINE_BUF_LINES,
   parameter int               BTT_N    = vps_pkg::BTT_ENTRIES,
   parameter logic [31:0]      RESET_PC = vps_pkg::RESET_PC
) (
   // clock and reset
   input  wire logic                  sys_clk_in,
   input  wire logic                  rst_n_in,
   // instruction memory
   output logic                       fetch_req_out,
   output logic [31:0]                fetch_addr_out,
   input  wire logic [127:0]          fetch_data_in,
   // issue to the units
   output logic                       issue_valid_out,
   output logic [127:0]               issue_line_out,
   output logic [3:0]                 issue_slot_en_out,
   output logic [7:0]                 issue_unit_out,
   output logic [31:0]                issue_pc_out,
   output logic                       issue_pred_out,
   input  wire logic [3:0]            cond_true_in,
   input  wire logic                  int_slow_in,
   // flow events from execution
   input  wire logic                  br_resolve_in,
   input  wire logic                  br_taken_in,
   input  wire logic                  br_pred_in,
   input  wire logic [31:0]           br_pc_in,
   input  wire logic [31:0]           br_target_in,
   input  wire logic                  rti_in,
   input  wire logic                  sw_exc_in,
   input  wire logic [31:0]           exc_vector_in,
   output logic                       ex_cancel_out,
   output logic                       retire_out,
   // interrupts
   input  wire logic [7:0]            irq_in,
   input  wire logic [7:0]            irq_mask_in,
   input  wire logic [3:0]            ext_edge_sel_in,
   input  wire logic                  nest_en_in,
   input  wire logic [31:0]           irq_vector_in [8],
   output logic [7:0]                 irq_latch_out,
   output logic [7:0]                 irq_service_out,
   output logic                       irq_ack_out
);
   localparam int QW    = LINES * vps_pkg::SLOTS;     // queue words
   localparam int CW    = $clog2(QW + 1);
   localparam int IW    = $clog2(BTT_N);               // table index
   localparam int TW    = vps_pkg::PC_W - IW - 2;      // table tag
   localparam int DW    = 1 + TW + 2 + vps_pkg::PC_W;  // valid,tag,last,target
   localparam int NI    = vps_pkg::NUM_IRQ;

   // ************************************************
   // elaboration checks
   // ************************************************
   if (LINES < 2 || BTT_N < 2 || (1 << IW) != BTT_N) begin : g_bad
      $error("line buffer or table size unsupported");
   end

   // ************************************************
   // state
   // ************************************************
   vps_btt_if #(.AW(IW), .DW(DW)) btt ();
   vps_pkg::vps_qent_t q      [QW]; // line buffer words, head at 0
   vps_pkg::vps_qent_t next_q [QW];
   logic [CW-1:0]      cnt, next_cnt;            // words held
   logic [31:0]        fetch_pc, next_fetch_pc;  // next fetch word
   logic [2:0]         fp_v;                     // fetch pipe valids
   logic [1:0]         fp_skip [3];              // first wanted word
   logic [1:0]         fp_last [3];              // last wanted word
   logic               fp_pred [3];              // quad ends predicted
   logic [31:0]        fp_pc   [3];              // quad base address
   logic [5:0]         ex_v;                     // execution stages
   logic [63:0]        pend_c, pend_i;           // results not yet ready
   logic [63:0]        cmask, imask;
   vps_pkg::vps_state_t state;
   logic [2:0]         irq_src;                  // source being entered
   logic [7:0]         irq_prev;
   logic [31:0]        ret_pc [8];               // return per source
   // combinational terms
   logic [3:0]  ends;
   logic [2:0]  len;
   logic        hazard, do_issue, mispredict, enter, redirect, hit, next_req;
   logic [31:0] redirect_pc;
   logic [7:0]  edge_mode, irq_set;
   int          p_idx, s_idx, base, pop, k, added;

   // lowest set index, or NI when none
   function automatic int first_set(input logic [7:0] v);
      first_set = NI;
      for (int i = NI - 1; i >= 0; i--) begin
         if (v[i]) first_set = i;
      end
   endfunction

   // ************************************************
   // table instance
   // ************************************************
   vps_btt_mem #(.DEPTH(BTT_N), .AW(IW), .DW(DW)) u_btt (
      .sys_clk_in (sys_clk_in),
      .rst_n_in   (rst_n_in),
      .btt        (btt)
   );

   // ************************************************
   // issue decision and interlocks
   // ************************************************
   always_comb begin
      for (int s = 0; s < 4; s++) ends[s] = q[s].word[vps_pkg::END_BIT];
      len = 3'h4;
      for (int s = 3; s >= 0; s--) begin
         if (ends[s]) len = 3'(s + 1);
      end
      hazard = 1'b0;
      cmask  = '0;
      imask  = '0;
      for (int s = 0; s < 4; s++) begin
         if (s < int'(len)) begin
            // compute two-cycle and slow integer results
            if (pend_c[q[s].word[vps_pkg::SRC_HI:vps_pkg::SRC_LO]]) hazard = 1'b1;
            if (int_slow_in && pend_i[q[s].word[vps_pkg::SRC_HI:vps_pkg::SRC_LO]]) hazard = 1'b1;
            if (q[s].word[vps_pkg::UNIT_HI] == 1'b0) begin
               cmask[q[s].word[vps_pkg::DST_HI:vps_pkg::DST_LO]] = 1'b1;
            end else if (q[s].word[vps_pkg::UNIT_LO] == 1'b0) begin
               imask[q[s].word[vps_pkg::DST_HI:vps_pkg::DST_LO]] = 1'b1;
            end
         end
      end
      mispredict = br_resolve_in && (br_taken_in != br_pred_in);
      enter = (state == vps_pkg::ST_DRAIN) && (ex_v == '0) && (fp_v == '0)
              && !sw_exc_in && !mispredict && !rti_in;
      redirect = sw_exc_in || mispredict || rti_in || enter;
      // head line only, in buffer order
      do_issue = (cnt >= CW'(len)) && !hazard && (state == vps_pkg::ST_RUN) && !redirect;
      pop = do_issue ? int'(len) : 0;
   end

   // ************************************************
   // redirect target, by priority
   // ************************************************
   always_comb begin
      p_idx = first_set(irq_latch_out & irq_mask_in);
      s_idx = first_set(irq_service_out);
      if (sw_exc_in) redirect_pc = exc_vector_in;
      else if (mispredict) redirect_pc = br_taken_in ? br_target_in : br_pc_in + 32'h1;
      else if (rti_in) redirect_pc = (s_idx < NI) ? ret_pc[s_idx[2:0]] : fetch_pc;
      else redirect_pc = irq_vector_in[irq_src];
   end

   // ************************************************
   // fetch address and prediction
   // ************************************************
   always_comb begin
      hit = btt.rd_data[DW-1] && (btt.rd_data[DW-2 -: TW] == fetch_pc[31 -: TW]);
      next_req = (int'(cnt) + 4 * (int'(fp_v[0]) + int'(fp_v[1]) + int'(fp_v[2])) <= QW - 4)
                 && !redirect && (state == vps_pkg::ST_RUN);
      if (redirect) next_fetch_pc = redirect_pc;
      else if (next_req && hit) next_fetch_pc = btt.rd_data[31:0];
      else if (next_req) next_fetch_pc = {fetch_pc[31:2] + 30'h1, 2'h0};
      else next_fetch_pc = fetch_pc;
      btt.rd_addr = next_fetch_pc[IW+1:2];
      btt.wr_en   = br_resolve_in;
      btt.wr_addr = br_pc_in[IW+1:2];
      btt.wr_data = {br_taken_in, br_pc_in[31 -: TW], br_pc_in[1:0], br_target_in};
   end

   // fetch pipe, four stages ending in the align step
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         fetch_pc <= RESET_PC;
         fp_v     <= '0;
      end else begin
         fetch_pc <= next_fetch_pc;
         fp_v     <= redirect ? 3'h0 : {fp_v[1:0], next_req};
      end
   end

   // fetch pipe payload
   always_ff @(posedge sys_clk_in) begin
      fp_skip[0] <= fetch_pc[1:0];
      fp_last[0] <= hit ? btt.rd_data[33:32] : 2'h3;
      fp_pred[0] <= hit;
      fp_pc[0]   <= {fetch_pc[31:2], 2'h0};
      for (int i = 1; i < 3; i++) begin
         fp_skip[i] <= fp_skip[i-1];
         fp_last[i] <= fp_last[i-1];
         fp_pred[i] <= fp_pred[i-1];
         fp_pc[i]   <= fp_pc[i-1];
      end
   end
   assign fetch_req_out  = fp_v[0];
   assign fetch_addr_out = fp_pc[0];

   // ************************************************
   // line buffer: pop the issued line, append aligned words
   // ************************************************
   always_comb begin
      base  = int'(cnt) - pop;
      added = 0;
      k     = 0;
      for (int i = 0; i < QW; i++) begin
         next_q[i] = (i < base) ? q[i + pop] : q[i];
      end
      if (fp_v[2]) begin
         for (int j = 0; j < 4; j++) begin
            k = base + j - int'(fp_skip[2]);
            // drop words before the target and after a taken branch
            if (j >= int'(fp_skip[2]) && j <= int'(fp_last[2]) && k < QW) begin
               next_q[k].word = fetch_data_in[32*j +: 32];
               next_q[k].pc   = fp_pc[2] + 32'(j);
               next_q[k].pred = fp_pred[2] && (j == int'(fp_last[2]));
               added = added + 1;
            end
         end
      end
      next_cnt = redirect ? '0 : CW'(base + added);
   end

   // buffer storage
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         cnt <= '0;
      end else begin
         cnt <= next_cnt;
      end
      q <= next_q;
   end

   // ************************************************
   // issue outputs and routing
   // ************************************************
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         issue_valid_out   <= 1'b0;
         issue_line_out    <= '0;
         issue_slot_en_out <= '0;
         issue_unit_out    <= '0;
         issue_pc_out      <= '0;
         issue_pred_out    <= 1'b0;
      end else begin
         issue_valid_out <= do_issue;
         issue_pc_out    <= q[0].pc;
         issue_pred_out  <= q[len - 3'h1].pred;
         for (int s = 0; s < 4; s++) begin
            issue_line_out[32*s +: 32] <= q[s].word;
            issue_unit_out[2*s +: 2]   <= q[s].word[vps_pkg::UNIT_HI:vps_pkg::UNIT_LO];
            // false condition: slot not enabled
            issue_slot_en_out[s] <= do_issue && (s < int'(len))
               && (!q[s].word[vps_pkg::COND_BIT] || cond_true_in[s]);
         end
      end
   end

   // result readiness: compute two cycles, integer one, or two when int_slow_in
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         pend_c <= '0;
         pend_i <= '0;
      end else begin
         pend_c <= do_issue ? cmask : '0;
         pend_i <= do_issue ? imask : '0;
      end
   end

   // execution stages, cancelled by an exception
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         ex_v          <= '0;
         ex_cancel_out <= 1'b0;
      end else begin
         ex_v          <= sw_exc_in ? 6'h00 : {ex_v[4:0], do_issue};
         ex_cancel_out <= sw_exc_in;
      end
   end
   assign retire_out = ex_v[5];

   // ************************************************
   // interrupt latch, service and entry
   // ************************************************
   always_comb begin
      edge_mode = {vps_pkg::FIXED_EDGE[7:4], ext_edge_sel_in};
      irq_set   = irq_in & (~edge_mode | ~irq_prev);
   end

   // latch: a new event beats the entry clear
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         irq_prev      <= '0;
         irq_latch_out <= '0;
      end else begin
         irq_prev      <= irq_in;
         irq_latch_out <= (irq_latch_out & ~(enter ? (8'h01 << irq_src) : 8'h00)) | irq_set;
      end
   end

   // drain state and in-service bits
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         state           <= vps_pkg::ST_RUN;
         irq_src         <= '0;
         irq_service_out <= '0;
         irq_ack_out     <= 1'b0;
      end else begin
         irq_ack_out <= enter;
         case (state)
            vps_pkg::ST_RUN: begin
               // preempt only when nesting allows it
               if (p_idx < NI && (s_idx == NI || (nest_en_in && p_idx < s_idx)) && !redirect) begin
                  state   <= vps_pkg::ST_DRAIN;
                  irq_src <= p_idx[2:0];
               end
            end
            vps_pkg::ST_DRAIN: begin
               if (sw_exc_in || enter) state <= vps_pkg::ST_RUN;
            end
            default: state <= vps_pkg::ST_RUN;
         endcase
         if (enter) irq_service_out[irq_src] <= 1'b1;
         else if (rti_in && s_idx < NI) irq_service_out[s_idx[2:0]] <= 1'b0;
      end
   end

   // return address saved at entry
   always_ff @(posedge sys_clk_in) begin
      if (enter) ret_pc[irq_src] <= (cnt != '0) ? q[0].pc : fetch_pc;
   end

   // ************************************************
   // checks
   // ************************************************
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);

   a_issue_shape: assert property (issue_valid_out |-> issue_slot_en_out[0] || issue_line_out[28])
      else $error("issued line has no first slot");
   a_compute_stall: assert property (do_issue && cmask != '0 |=>
      pend_c == $past(cmask) && !(do_issue && hazard) ##1 pend_c == '0 || $past(do_issue))
      else $error("compute result used too early");
   a_int_stall: assert property (int_slow_in && hazard |-> !do_issue)
      else $error("issue despite unready integer result");
   a_buf_bound: assert property (int'(cnt) <= QW)
      else $error("line buffer overfilled");
   a_exc_cancel: assert property (sw_exc_in |=> ex_v == '0 && ex_cancel_out && cnt == '0 && fp_v == '0)
      else $error("exception left work in the pipeline");
   a_irq_drain: assert property (irq_ack_out |-> $past(ex_v) == '0 && $past(state) == vps_pkg::ST_DRAIN)
      else $error("interrupt entered with pipeline busy");
   a_cond_gate: assert property (issue_valid_out && issue_line_out[28] && !$past(cond_true_in[0])
      |-> !issue_slot_en_out[0])
      else $error("false condition slot enabled");
   a_mispredict_flush: assert property (mispredict && !sw_exc_in |=>
      cnt == '0 && fp_v == '0 ##1 fetch_req_out)
      else $error("mispredict did not flush and refetch");
   a_in_order: assert property (issue_valid_out && !$past(redirect, 2) ##1 issue_valid_out |->
      issue_pc_out != $past(issue_pc_out))
      else $error("line issued twice or out of order");
endmodule
`default_nettype wire

// ==== dv/vps_imem_model.sv ====
/*
 * instruction memory model: answers each fetch request with a quad.
 * assumes the core clock; data is valid at the second edge after req.
 */
`timescale 1ns/1ps
`default_nettype none
module vps_imem_model (
   // clock and reset
   input  wire logic         sys_clk_in,
   input  wire logic         rst_n_in,
   // fetch side
   input  wire logic         fetch_req_in,
   input  wire logic [31:0]  fetch_addr_in,
   output logic [127:0]      fetch_data_out
);
   logic        pend;  // request one cycle old
   logic [31:0] paddr; // its quad address
   // one-word lines; from 0x100 up compute and integer lines alternate,
   // each reading the dest of the line before it
   function automatic logic [31:0] word(input logic [31:0] a);
      if (a >= 32'h0000_0100) begin
         return {1'h1, a[0], 1'h0, 1'h0, 6'h01, 6'h01, a[15:0]};
      end
      return {1'h1, a[2:1], a[0], 6'h01, 6'h02, a[15:0]};
   endfunction
   // quad two edges after request, inverted filler otherwise
   always_ff @(posedge sys_clk_in) begin
      pend  <= fetch_req_in & rst_n_in;
      paddr <= fetch_addr_in;
      if (!rst_n_in) begin
         fetch_data_out <= 128'h0;
      end else if (pend) begin
         fetch_data_out <= {word(paddr + 3), word(paddr + 2), word(paddr + 1), word(paddr)};
      end else begin
         fetch_data_out <= ~fetch_data_out;
      end
   end
endmodule
`default_nettype wire

// ==== dv/vps_sequencer_tb.sv ====
/*
 * bench for the sequencer: stream, redirect, exception, interrupt.
 * assumes the memory model answers fetches; events come from here.
 */
`timescale 1ns/1ps
`default_nettype none
module vps_sequencer_tb;
   // ************************************************
   // signals
   // ************************************************
   logic         sys_clk_in = 1'b0;    // core clock
   logic         rst_n_in = 1'b0;      // held low at start
   logic         fetch_req_out;        // fetch side
   logic [31:0]  fetch_addr_out;
   logic [127:0] fetch_data_in;
   logic         issue_valid_out;      // issue side
   logic [3:0]   issue_slot_en_out;
   logic [7:0]   issue_unit_out;
   logic [31:0]  issue_pc_out;
   logic [3:0]   cond_true_in = 4'h0;  // slot conditions
   logic         int_slow_in = 1'b0;   // integer results late
   logic         br_resolve_in = 1'b0; // flow events
   logic         br_taken_in = 1'b0;
   logic [31:0]  br_target_in = 32'h0;
   logic         rti_in = 1'b0;
   logic         sw_exc_in = 1'b0;
   logic         ex_cancel_out;
   logic         retire_out;
   logic [7:0]   irq_in = 8'h0;        // interrupts
   logic [7:0]   irq_mask_in = 8'h0;
   logic [31:0]  irq_vector_in [8] = '{default: 32'h0};
   logic [7:0]   irq_latch_out;
   logic [7:0]   irq_service_out;
   logic         irq_ack_out;
   int           n_errors = 0;
   int           tests_run = 0;
   int           since_issue = 0;      // edges since last issued line
   vps_sequencer dut_u (
      .sys_clk_in, .rst_n_in, .fetch_req_out, .fetch_addr_out, .fetch_data_in,
      .issue_valid_out, .issue_line_out(), .issue_slot_en_out, .issue_unit_out, .issue_pc_out,
      .issue_pred_out(), .cond_true_in, .int_slow_in, .br_resolve_in, .br_taken_in,
      .br_pred_in(1'b0), .br_pc_in(~br_target_in), .br_target_in, .rti_in, .sw_exc_in,
      .exc_vector_in(br_target_in), .ex_cancel_out, .retire_out, .irq_in, .irq_mask_in,
      .ext_edge_sel_in(4'h0), .nest_en_in(1'b0), .irq_vector_in, .irq_latch_out,
      .irq_service_out, .irq_ack_out);
   vps_imem_model mem_u (.sys_clk_in, .rst_n_in, .fetch_req_in(fetch_req_out),
      .fetch_addr_in(fetch_addr_out), .fetch_data_out(fetch_data_in));
   // clock and drain counter
   initial forever #5 sys_clk_in = ~sys_clk_in;
   always @(posedge sys_clk_in) since_issue <= issue_valid_out ? 0 : since_issue + 1;
   // ************************************************
   // helpers
   // ************************************************
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tick;
      @(posedge sys_clk_in);
      #1;
   endtask
   // bounded wait: 0 issue, 1 fetch, 2 interrupt entry
   task automatic wait_for(input int sel, input int bound);
      for (int i = 0; i < bound; i++) begin
         tick();
         if ((sel == 0 && issue_valid_out === 1'b1) || (sel == 1 && fetch_req_out === 1'b1)
             || (sel == 2 && irq_ack_out === 1'b1)) begin
            return;
         end
      end
      n_errors++;
      $display("BAD wait %0d expected event seen none", sel);
      summarize();
   endtask
   // one-cycle event: 0 taken mispredict, 1 exception, 2 return
   task automatic pulse(input int sel, input logic [31:0] tgt);
      @(posedge sys_clk_in);
      br_target_in <= tgt;
      br_resolve_in <= (sel == 0);
      br_taken_in <= (sel == 0);
      sw_exc_in <= (sel == 1);
      rti_in <= (sel == 2);
      @(posedge sys_clk_in);
      br_resolve_in <= 1'b0;
      br_taken_in <= 1'b0;
      sw_exc_in <= 1'b0;
      rti_in <= 1'b0;
      #1;
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // ************************************************
   // scenarios
   // ************************************************
   task automatic test_stream;
      wait_for(0, 40);
      chk("reset pc", 32'h0, issue_pc_out);
      for (int i = 1; i <= 6; i++) begin
         tick();
         chk("valid", 1, issue_valid_out);
         chk("pc", i, issue_pc_out);
         chk("slots", {3'h0, ~i[0]}, issue_slot_en_out);
         chk("unit", i[2:1], issue_unit_out[1:0]);
         chk("retire", i >= 5, retire_out);
      end
      $display("done stream");
   endtask
   task automatic test_redirect;
      @(posedge sys_clk_in);
      int_slow_in <= 1'b1;
      pulse(0, 32'h100);
      wait_for(1, 4);
      chk("redirect addr", 32'h100, fetch_addr_out);
      wait_for(0, 12);
      chk("target pc", 32'h100, issue_pc_out);
      tick();
      chk("stall", 0, issue_valid_out);
      tick();
      chk("after stall", 1, issue_valid_out);
      chk("next pc", 32'h101, issue_pc_out);
      tick();
      chk("int stall", 0, issue_valid_out);
      tick();
      chk("int resume", 1, issue_valid_out);
      chk("int pc", 32'h102, issue_pc_out);
      @(posedge sys_clk_in);
      int_slow_in <= 1'b0;
      cond_true_in <= 4'hf;
      $display("done redirect");
   endtask
   task automatic test_exception;
      pulse(1, 32'h40);
      chk("cancel", 1, ex_cancel_out);
      wait_for(1, 4);
      chk("handler fetch", 32'h40, fetch_addr_out);
      wait_for(0, 12);
      chk("handler pc", 32'h40, issue_pc_out);
      tick();
      chk("cond slot", 1, issue_slot_en_out[0]);
      chk("cond pc", 32'h41, issue_pc_out);
      $display("done exception");
   endtask
   task automatic test_irq;
      @(posedge sys_clk_in);
      irq_vector_in[4] <= 32'h80;
      irq_mask_in <= 8'h10;
      irq_in <= 8'h10;
      wait_for(2, 60);
      chk("drain gap", 1, since_issue >= 6);
      chk("service", 8'h10, irq_service_out);
      chk("latch kept", 8'h10, irq_latch_out);
      wait_for(1, 4);
      chk("vector fetch", 32'h80, fetch_addr_out);
      @(posedge sys_clk_in);
      irq_in <= 8'h0;
      irq_mask_in <= 8'h0;
      pulse(2, 32'h0);
      chk("return clears", 8'h0, irq_service_out);
      $display("done interrupt");
   endtask
   // main sequence
   initial begin
      repeat (16) @(posedge sys_clk_in);
      rst_n_in <= 1'b1;
      test_stream();
      test_redirect();
      test_exception();
      test_irq();
      summarize();
   end
endmodule
`default_nettype wire
